// *** charge_guard_pkg.sv ***
// Shared constants and state types for the charge path fault supervisor
package charge_guard_pkg;
	localparam int unsigned CLK_HZ          = 10_000_000;
	localparam int unsigned SETTLE_US       = 10_000;
	localparam int unsigned SETTLE_CYC      = (SETTLE_US * (CLK_HZ / 1_000_000) > 0) ? SETTLE_US * (CLK_HZ / 1_000_000) : 1;
	localparam int unsigned BLANK_US        = 180;
	localparam int unsigned BLANK_CYC       = (BLANK_US * (CLK_HZ / 1_000_000) > 0) ? BLANK_US * (CLK_HZ / 1_000_000) : 1;
	localparam int unsigned SOFT_US         = 1_000;
	localparam int unsigned SOFT_CYC        = (SOFT_US * (CLK_HZ / 1_000_000) > 0) ? SOFT_US * (CLK_HZ / 1_000_000) : 1;
	localparam int unsigned SLOW_OFF_US     = 50;
	localparam int unsigned SLOW_OFF_CYC    = (SLOW_OFF_US * (CLK_HZ / 1_000_000) > 0) ? SLOW_OFF_US * (CLK_HZ / 1_000_000) : 1;
	localparam int unsigned TIMER_W         = 20;
	localparam int unsigned GATE_W          = 8;
	localparam int unsigned EVT_W           = 4;
	localparam logic [GATE_W-1:0] GATE_FULL = 8'hFF;
	localparam logic [GATE_W-1:0] GATE_ZERO = 8'h00;
	localparam logic [EVT_W-1:0]  EVT_LAST  = 4'hF;
	localparam logic [EVT_W-1:0]  EVT_ZERO  = 4'h0;
	localparam logic [TIMER_W-1:0] TMR_ZERO = 20'h00000;
	localparam logic [TIMER_W-1:0] TMR_ONE  = 20'h00001;

	typedef enum logic [2:0] {
		ST_OFF     = 3'b000,
		ST_SETTLE  = 3'b001,
		ST_SOFT    = 3'b010,
		ST_ON      = 3'b011,
		ST_RAMPDN  = 3'b100,
		ST_FAULT   = 3'b101,
		ST_LATCHED = 3'b110
	} sup_state_t;

	typedef enum logic [1:0] {
		CAUSE_NONE = 2'b00,
		CAUSE_BOV  = 2'b01,
		CAUSE_OC   = 2'b10,
		CAUSE_HOT  = 2'b11
	} cause_t;

	typedef struct packed {
		logic in_ov;
		logic bat_ov;
		logic over_cur;
		logic hot;
		logic cool;
	} faults_t;

	typedef struct packed {
		sup_state_t         st;
		cause_t             cause;
		logic [TIMER_W-1:0] tmr;
		logic [TIMER_W-1:0] bov_blank;
		logic [TIMER_W-1:0] oc_blank;
		logic [EVT_W-1:0]   bov_cnt;
		logic [EVT_W-1:0]   oc_cnt;
		logic               bov_dead;
		logic               oc_dead;
		logic               en_prev;
		logic [GATE_W-1:0]  gate;
		logic               flag;
	} sup_regs_t;
endpackage

// *** charge_path_fault_supervisor.sv ***
// Control logic of the charging-path safety switch
`timescale 1ns/100ps

// Overview of operation
// R01: Switch off while supply below reset threshold
// R02: After supply good, wait 10ms then start
// R03: Soft-start ramps switch gate gradually
// R04: Input overvoltage kills switch within 1us
// R05: Input overvoltage clear reruns delay and soft-start
// R06: Input overvoltage during delay blocks soft-start
// R07: Battery overvoltage needs full 180us blanking
// R08: Sixteenth battery overvoltage event latches off
// R09: Power cycling clears battery counter, restarts
// R10: Overcurrent needs 180us qualification before off
// R11: Sixteenth overcurrent event latches off
// R12: Overcurrent latch cleared by power or enable
// R13: Die at 150C turns switch off
// R14: Stay off until die below 110C
// R15: Fault flag low while protection holds off
// R16: Slow turn-off for overcurrent, battery overvoltage
// R17: Enable low turns off, high restarts
// R18: Counters step once per qualified fault entry
module charge_path_fault_supervisor
	import charge_guard_pkg::*;
(
	input  wire logic              REF_CLK,       // 10 MHz timebase
	input  wire logic              ARST_N,        // Supply supervisor, low below reset threshold
	input  wire logic              ENABLE,        // Enable from external controller
	input  wire logic              INPUT_OV,      // Input overvoltage comparator
	input  wire logic              BATTERY_OV,    // Battery overvoltage comparator
	input  wire logic              OVER_CURRENT,  // Overcurrent comparator
	input  wire logic              DIE_HOT,       // Die at or above 150 C
	input  wire logic              DIE_COOL,      // Die below 110 C
	output logic [GATE_W-1:0]      SWITCH_GATE,   // Switch gate drive level
	output logic                   SWITCH_ON,     // Switch fully enabled
	output logic                   FAULT_O,       // Fault pin output value, always low
	output logic                   FAULT_OE_N     // Fault pin drive enable, low pulls pin low
);

	sup_regs_t q_r;
	sup_regs_t q_nxt;
	faults_t   f;

	always_comb begin
		f.in_ov    = INPUT_OV;
		f.bat_ov   = BATTERY_OV;
		f.over_cur = OVER_CURRENT;
		f.hot      = DIE_HOT;
		f.cool     = DIE_COOL;
	end

	function automatic logic [TIMER_W-1:0] count_up(input logic [TIMER_W-1:0] v, input logic hold);
		count_up = hold ? ((v == TIMER_W'(BLANK_CYC)) ? v : v + TMR_ONE) : TMR_ZERO;
	endfunction

	function automatic logic [EVT_W-1:0] bump(input logic [EVT_W-1:0] v);
		bump = (v == EVT_LAST) ? v : v + 4'h1;
	endfunction

	logic bov_qual;
	logic oc_qual;
	logic restart_ok;

	always_comb begin
		q_nxt      = q_r;
		q_nxt.en_prev = ENABLE;
		// Blanking counters only run with the switch conducting
		q_nxt.bov_blank = count_up(q_r.bov_blank, f.bat_ov && (q_r.st == ST_ON || q_r.st == ST_SOFT)); // [R07]
		q_nxt.oc_blank  = count_up(q_r.oc_blank, f.over_cur && (q_r.st == ST_ON || q_r.st == ST_SOFT)); // [R10]
		bov_qual   = (q_r.bov_blank == TIMER_W'(BLANK_CYC - 1)) && f.bat_ov; // [R07]
		oc_qual    = (q_r.oc_blank == TIMER_W'(BLANK_CYC - 1)) && f.over_cur; // [R10]
		restart_ok = ENABLE && !f.in_ov && !q_r.bov_dead && !q_r.oc_dead && !f.hot;

		// Enable rising edge releases the overcurrent latch only
		if (ENABLE && !q_r.en_prev) begin
			q_nxt.oc_dead = 1'b0; // [R12]
			q_nxt.oc_cnt  = EVT_ZERO; // [R12]
		end

		case (q_r.st)
			ST_OFF: begin
				q_nxt.gate = GATE_ZERO;
				// Flag holds while input overvoltage keeps the switch off
				q_nxt.flag = f.in_ov; // [R15]
				if (f.hot) begin
					// Hot die must cool past the low threshold before any restart
					q_nxt.st    = ST_FAULT; // [R13] [R14]
					q_nxt.cause = CAUSE_HOT;
					q_nxt.flag  = 1'b1; // [R15]
				end else if (restart_ok && !(q_r.oc_dead && !(ENABLE && !q_r.en_prev))) begin
					q_nxt.st  = ST_SETTLE; // [R02] [R05] [R17]
					q_nxt.tmr = TMR_ZERO;
				end
			end
			ST_SETTLE: begin
				q_nxt.gate = GATE_ZERO;
				q_nxt.tmr  = q_r.tmr + TMR_ONE;
				if (!ENABLE || f.in_ov || f.hot) begin
					q_nxt.st   = ST_OFF; // [R06] [R17]
					q_nxt.flag = f.in_ov || f.hot;
				end else if (q_r.tmr == TIMER_W'(SETTLE_CYC - 1)) begin
					q_nxt.st  = ST_SOFT; // [R02]
					q_nxt.tmr = TMR_ZERO;
				end
			end
			ST_SOFT, ST_ON: begin
				if (q_r.st == ST_SOFT) begin
					// Gate steps up evenly over the soft-start window
					q_nxt.tmr = q_r.tmr + TMR_ONE;
					if (q_r.tmr == TIMER_W'(SOFT_CYC - 1)) begin
						q_nxt.gate = GATE_FULL; // [R03]
						q_nxt.st   = ST_ON;
					end else begin
						// Product needs 32 bits, a timer-wide product would wrap
						q_nxt.gate = GATE_W'((32'(q_r.tmr) * 32'(GATE_FULL)) / 32'(SOFT_CYC)); // [R03]
					end
				end
				if (f.in_ov) begin
					q_nxt.gate  = GATE_ZERO; // [R04] [R16]
					q_nxt.st    = ST_OFF;
					q_nxt.flag  = 1'b1; // [R15]
				end else if (!ENABLE) begin
					q_nxt.gate  = GATE_ZERO; // [R17]
					q_nxt.st    = ST_OFF;
				end else if (f.hot) begin
					q_nxt.st    = ST_RAMPDN; // [R13]
					q_nxt.cause = CAUSE_HOT;
					q_nxt.tmr   = TMR_ZERO;
					q_nxt.flag  = 1'b1; // [R15]
				end else if (bov_qual) begin
					q_nxt.st    = ST_RAMPDN; // [R07] [R16]
					q_nxt.cause = CAUSE_BOV;
					q_nxt.tmr   = TMR_ZERO;
					q_nxt.flag  = 1'b1; // [R15]
					q_nxt.bov_cnt = bump(q_r.bov_cnt); // [R08] [R18]
					q_nxt.bov_dead = (q_r.bov_cnt == EVT_LAST) || q_r.bov_dead; // [R08]
				end else if (oc_qual) begin
					q_nxt.st    = ST_RAMPDN; // [R10] [R16]
					q_nxt.cause = CAUSE_OC;
					q_nxt.tmr   = TMR_ZERO;
					q_nxt.flag  = 1'b1; // [R15]
					q_nxt.oc_cnt = bump(q_r.oc_cnt); // [R11] [R18]
					q_nxt.oc_dead = (q_r.oc_cnt == EVT_LAST) || q_r.oc_dead; // [R11]
				end
			end
			ST_RAMPDN: begin
				// Slow discharge keeps input overshoot small
				q_nxt.tmr  = q_r.tmr + TMR_ONE;
				q_nxt.gate = (q_r.gate > GATE_W'(1)) ? q_r.gate - GATE_W'(1) : GATE_ZERO; // [R16]
				if (f.in_ov || q_r.tmr == TIMER_W'(SLOW_OFF_CYC - 1)) begin
					q_nxt.gate = GATE_ZERO; // [R04] [R16]
					q_nxt.st   = (q_r.bov_dead || q_r.oc_dead) ? ST_LATCHED : ST_FAULT;
				end
			end
			ST_FAULT: begin
				q_nxt.gate = GATE_ZERO;
				q_nxt.flag = 1'b1; // [R15]
				if (q_r.cause == CAUSE_HOT) begin
					if (f.cool && !f.hot) begin
						q_nxt.st    = ST_OFF; // [R14]
						q_nxt.cause = CAUSE_NONE;
					end
				end else if (!f.bat_ov && !f.over_cur) begin
					// Retry once both battery and current comparators have cleared
					q_nxt.st    = ST_OFF;
					q_nxt.cause = CAUSE_NONE;
				end
			end
			ST_LATCHED: begin
				q_nxt.gate = GATE_ZERO;
				q_nxt.flag = 1'b1; // [R08] [R11] [R15]
				// Battery latch never clears here; only supply loss does
				if (!q_r.bov_dead && ENABLE && !q_r.en_prev) begin
					q_nxt.st    = ST_OFF; // [R12]
					q_nxt.cause = CAUSE_NONE;
					q_nxt.flag  = 1'b0;
				end
			end
			default: begin
				q_nxt.st   = ST_OFF;
				q_nxt.gate = GATE_ZERO;
			end
		endcase
	end

	// Supply supervisor is the only reset, so power cycling clears everything
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			q_r <= '{st: ST_OFF, cause: CAUSE_NONE, tmr: TMR_ZERO, bov_blank: TMR_ZERO, oc_blank: TMR_ZERO,
				bov_cnt: EVT_ZERO, oc_cnt: EVT_ZERO, bov_dead: 1'b0, oc_dead: 1'b0, en_prev: 1'b0,
				gate: GATE_ZERO, flag: 1'b0}; // [R01] [R09]
		end else begin
			q_r <= q_nxt;
		end
	end

	// Input overvoltage bypasses the register for sub-microsecond cut
	always_comb begin
		SWITCH_GATE = (f.in_ov || !ARST_N) ? GATE_ZERO : q_r.gate; // [R01] [R04]
	end

	assign SWITCH_ON  = (q_r.st == ST_ON) && !f.in_ov;
	assign FAULT_O    = 1'b0;
	assign FAULT_OE_N = !q_r.flag; // [R15]

endmodule

// *** fault_host.sv ***
// Host side of the open-drain fault line
`timescale 1ns/100ps
module fault_host (
	input  wire logic fault_o,    // Pin data
	input  wire logic fault_oe_n, // Pin drive enable
	output logic      line        // Level seen by host
);
	// Pull-up wins when the pin floats
	assign line = fault_oe_n ? 1'b1 : fault_o;
endmodule

// *** supervisor_properties.sv ***
// Port checker for the charge path fault supervisor
`timescale 1ns/100ps
module supervisor_properties
	import charge_guard_pkg::*;
(
	input wire logic              REF_CLK,      // Clock
	input wire logic              ARST_N,       // Reset
	input wire logic              ENABLE,       // Enable
	input wire logic              INPUT_OV,     // Input OV
	input wire logic              BATTERY_OV,   // Battery OV
	input wire logic              OVER_CURRENT, // Overcurrent
	input wire logic              DIE_HOT,      // Hot die
	input wire logic              DIE_COOL,     // Cool die
	input wire logic [GATE_W-1:0] SWITCH_GATE,  // Gate
	input wire logic              SWITCH_ON,    // On
	input wire logic              FAULT_O,      // Flag data
	input wire logic              FAULT_OE_N    // Flag enable
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!ARST_N);
	logic [11:0] bov_run_r;
	logic [11:0] oc_run_r;
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			bov_run_r <= 12'h000;
			oc_run_r  <= 12'h000;
		end else begin
			bov_run_r <= BATTERY_OV ? bov_run_r + 12'h001 : 12'h000;
			oc_run_r  <= OVER_CURRENT ? oc_run_r + 12'h001 : 12'h000;
		end
	end
	a_reset_gate_off: assert property (disable iff (1'b0) !ARST_N |-> SWITCH_GATE == GATE_ZERO && !SWITCH_ON)
		else $error("gate not off in reset");
	a_inov_kills_gate: assert property (INPUT_OV |-> SWITCH_GATE == GATE_ZERO && !SWITCH_ON)
		else $error("gate on during input overvoltage");
	a_on_full_gate: assert property (SWITCH_ON |-> SWITCH_GATE == GATE_FULL)
		else $error("switch on without full gate");
	a_no_step_on: assert property ($past(SWITCH_GATE) == GATE_ZERO && !$past(INPUT_OV) |-> SWITCH_GATE != GATE_FULL)
		else $error("gate jumped to full");
	// Slack of two cycles covers the sampling skew of the run counters
	a_flag_has_cause: assert property ($fell(FAULT_OE_N) |-> $past(INPUT_OV) || $past(DIE_HOT)
		|| bov_run_r >= 12'd1798 || oc_run_r >= 12'd1798)
		else $error("flag fell without qualified fault");
	a_inov_flag: assert property ($past(SWITCH_ON) && INPUT_OV && !$past(INPUT_OV) |=> !FAULT_OE_N)
		else $error("flag missing after input overvoltage");
	a_enable_drop: assert property (SWITCH_ON && !ENABLE |=> SWITCH_GATE == GATE_ZERO && FAULT_OE_N)
		else $error("enable low did not turn off");
	a_hot_off: assert property (SWITCH_ON && DIE_HOT |=> !SWITCH_ON)
		else $error("hot die left switch on");
	a_slow_off: assert property ($fell(FAULT_OE_N) && $past(SWITCH_ON) && !$past(INPUT_OV) |-> SWITCH_GATE != GATE_ZERO)
		else $error("slow turn-off dropped gate at once");
	a_drive_low: assert property (FAULT_O == 1'b0)
		else $error("flag data not low");
	c_on: cover property ($rose(SWITCH_ON));
	c_flag: cover property ($fell(FAULT_OE_N));
	c_inov: cover property (INPUT_OV && $past(SWITCH_ON));
endmodule
bind charge_path_fault_supervisor supervisor_properties u_props (.REF_CLK(REF_CLK), .ARST_N(ARST_N),
	.ENABLE(ENABLE), .INPUT_OV(INPUT_OV), .BATTERY_OV(BATTERY_OV), .OVER_CURRENT(OVER_CURRENT),
	.DIE_HOT(DIE_HOT), .DIE_COOL(DIE_COOL), .SWITCH_GATE(SWITCH_GATE), .SWITCH_ON(SWITCH_ON),
	.FAULT_O(FAULT_O), .FAULT_OE_N(FAULT_OE_N));

// *** tb_top.sv ***
// Self-checking bench for the charge path fault supervisor
`timescale 1ns/100ps
module tb_top
	import charge_guard_pkg::*;
	;
	logic ref_clk = 0, arst_n = 0, enable = 0, in_ov = 0, bat_ov = 0, over_cur = 0, die_hot = 0, die_cool = 1;
	logic [GATE_W-1:0] gate;
	logic              sw_on, f_o, f_oe_n, line;
	int                error_cnt = 0, samples_checked = 0, n;
	int                lens[4] = '{1, 1790, 1, 1790};
	always #50 ref_clk = ~ref_clk;
	charge_path_fault_supervisor dut (.REF_CLK(ref_clk), .ARST_N(arst_n), .ENABLE(enable), .INPUT_OV(in_ov),
		.BATTERY_OV(bat_ov), .OVER_CURRENT(over_cur), .DIE_HOT(die_hot), .DIE_COOL(die_cool),
		.SWITCH_GATE(gate), .SWITCH_ON(sw_on), .FAULT_O(f_o), .FAULT_OE_N(f_oe_n));
	fault_host host (.fault_o(f_o), .fault_oe_n(f_oe_n), .line(line));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("Checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Bounded wait on a wanted level of one output
	task automatic wait_for(ref logic sig, input logic lvl, input int lim);
		n = 0;
		while (sig !== lvl && n < lim) begin
			@(negedge ref_clk);
			n++;
		end
		if (n >= lim) begin
			error_cnt++;
			end_of_test();
		end
	endtask
	initial begin
		repeat (3) @(negedge ref_clk);
		chk({6'h00, f_oe_n, sw_on}, 8'h02);
		chk(gate, GATE_ZERO);
		@(posedge ref_clk) arst_n <= 1'b1;
		enable <= 1'b1;
		in_ov <= 1'b1;
		repeat (20) @(negedge ref_clk);
		chk(gate, GATE_ZERO);
		@(posedge ref_clk) in_ov <= 1'b0;
		wait_for(sw_on, 1'b1, 120000);
		chk({7'h00, n >= SETTLE_CYC}, 8'h01);
		chk(gate, GATE_FULL);
		$display("power-up done");
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk) {over_cur, bat_ov} <= i[1] ? 2'b10 : 2'b01;
			repeat (lens[i]) @(posedge ref_clk);
			{over_cur, bat_ov} <= 2'b00;
			repeat (5) @(negedge ref_clk);
			chk({6'h00, line, sw_on}, 8'h03);
			$display("short pulse row %0d done", i);
		end
		@(posedge ref_clk) bat_ov <= 1'b1;
		wait_for(f_oe_n, 1'b0, 2000);
		chk({7'h00, line}, 8'h00);
		chk({7'h00, gate != GATE_ZERO}, 8'h01);
		@(posedge ref_clk) bat_ov <= 1'b0;
		$display("battery fault done");
		@(posedge ref_clk) in_ov <= 1'b1;
		@(negedge ref_clk);
		chk(gate, GATE_ZERO);
		repeat (5) @(negedge ref_clk);
		chk({7'h00, line}, 8'h00);
		$display("input overvoltage done");
		@(posedge ref_clk) begin
			in_ov    <= 1'b0;
			die_hot  <= 1'b1;
			die_cool <= 1'b0;
		end
		repeat (5) @(negedge ref_clk);
		chk({7'h00, line}, 8'h00);
		@(posedge ref_clk) die_hot <= 1'b0;
		repeat (5) @(negedge ref_clk);
		chk({7'h00, line}, 8'h00);
		@(posedge ref_clk) die_cool <= 1'b1;
		repeat (5) @(negedge ref_clk);
		chk({7'h00, line}, 8'h01);
		$display("over-temperature done");
		@(posedge ref_clk) enable <= 1'b0;
		repeat (5) @(negedge ref_clk);
		chk({gate[6:0], line}, 8'h01);
		@(posedge ref_clk) enable <= 1'b1;
		repeat (5) @(negedge ref_clk);
		chk({6'h00, line, sw_on}, 8'h02);
		$display("enable toggle done");
		@(posedge ref_clk) arst_n <= 1'b0;
		repeat (2) @(negedge ref_clk);
		chk({6'h00, f_oe_n, sw_on}, 8'h02);
		chk(gate, GATE_ZERO);
		@(posedge ref_clk) arst_n <= 1'b1;
		repeat (3) @(negedge ref_clk);
		chk({6'h00, line, sw_on}, 8'h02);
		$display("mid-run reset done");
		end_of_test();
	end
endmodule
